// ==== logic/psg_pkg.sv ====
// Package for the peripheral select and interrupt glue block.
// Assumes a single clock domain and a port address bus of eight bits.
package psg_pkg;
    // Port address group codes on address bits 5..3.
    localparam logic [2:0] GRP_PARALLEL = 3'h0;
    localparam logic [2:0] GRP_TIMER = 3'h1;
    localparam logic [2:0] GRP_INTC = 3'h2;
    localparam logic [2:0] GRP_SERIAL = 3'h3;
    localparam int GRP_LSB = 3;
    localparam int GRP_MSB = 5;
    // Controller register index on address bit 1, since the controller sits on even addresses only.
    localparam logic CTL_VECTOR = 1'h0;
    localparam logic CTL_MASK = 1'h1;
    // Reset values of the controller registers.
    localparam logic [7:0] VECTOR_BASE_RST = 8'h08;
    localparam logic [7:0] MASK_RST = 8'hFF;
    // Request input positions at the controller.
    localparam int IRQ_TIMER0 = 0;
    localparam int IRQ_TIMER1 = 1;
    localparam int IRQ_RX_READY = 2;
    localparam int IRQ_TX_READY = 3;
    localparam int IRQ_LOW_PC0 = 4;
    localparam int IRQ_LOW_PC3 = 5;
    localparam int IRQ_HIGH_PC0 = 6;
    localparam int IRQ_HIGH_PC3 = 7;
    // Peripheral clock is the processor clock divided by this figure.
    localparam int PCLK_DIVIDE = 2;
    // Acknowledge sequence states, one-hot.
    typedef enum logic [1:0] {
        ACK_IDLE = 2'h1,
        ACK_FIRST = 2'h2
    } psg_ack_e;
endpackage : psg_pkg

// ==== logic/psg_glue.sv ====
// Peripheral select decoder, timer clock routing and interrupt controller glue.
// Assumes a bus master giving one-cycle read and write strobes with a latched port address.
//
// Function
// - Parallel port low device on even, high device on odd addresses in group 0000xxx.
// - Parallel ports and timer select registers with the two lowest address lines.
// - Port C bits zero and three of each parallel device feed the controller.
// - Timer uses the low byte, selected on even addresses in 0001xxx.
// - Timer counters zero and two run from the peripheral clock.
// - A link clocks counter one from peripheral clock or counter zero output.
// - All three timer gate inputs are held high.
// - Counter two output is the serial bit-rate clock.
// - Counter zero and one outputs are controller request sources.
// - Controller uses low byte, address bit one, even addresses in 00010xxx.
// - Eight fixed-priority request levels, input zero highest, input seven lowest.
// - Controller raises request; two acknowledge pulses then place vector on bus.
// - Controller is a lone master; cascade unused, program input tied high.
// - Serial device selected on 00011xx0 and uses the low data byte.
// - Address line one picks serial control/status or data register.
// - Every system reset also resets the serial device.
// - Serial receive-ready and transmit-ready feed the controller.
// - A fitted link loops request-to-send back to clear-to-send.
// - Port decoder is active only during an I/O cycle.
// - All decoded select outputs are active low.
// - Peripheral clock is processor clock halved, with even duty.
`timescale 1ns/1ps
module psg_glue (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] portAddr,
    input wire logic byteHighEnableN,
    input wire logic memoryCycle,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    output logic dataDriveN,
    output logic periphReadN,
    output logic periphWriteN,
    output logic parallelLowSelN,
    output logic parallelHighSelN,
    output logic timerSelN,
    output logic intcSelN,
    output logic serialSelN,
    output logic [3:0] spareSelN,
    output logic [1:0] registerSelect,
    output logic serialCtrlSelect,
    output logic peripheralClock,
    output logic [2:0] timerClock,
    output logic [2:0] timerGate,
    input wire logic [2:0] counterOut,
    input wire logic counterOneLinkB,
    output logic receiveBitClock,
    output logic transmitBitClock,
    input wire logic receiveReadyFlag,
    input wire logic transmitReadyFlag,
    input wire logic [1:0] portCBitZero,
    input wire logic [1:0] portCBitThree,
    output logic serialReset,
    input wire logic handshakeLoopbackLink,
    input wire logic serialRtsN,
    input wire logic lineCtsN,
    output logic serialCtsN,
    output logic cpuInterruptRequest,
    input wire logic interruptAcknowledgePulse,
    output logic [2:0] cascadeLine,
    output logic masterSlaveProgramInput
);
    logic ioSelectable;
    logic strobeActive;
    logic [2:0] group;
    logic [7:0] requests;
    logic [7:0] pending;
    logic [2:0] topLevel;
    logic [2:0] heldLevel;
    logic [7:0] vectorBase;
    logic [7:0] mask;
    logic intcAccess;
    psg_pkg::psg_ack_e ackState;

    // Decoder enable: I/O cycle, upper address bits clear, a strobe present.
    // I/O cycle gate.
    assign ioSelectable = !memoryCycle && (portAddr[7:6] == 2'h0);
    assign strobeActive = readStrobe || writeStrobe;
    assign group = portAddr[psg_pkg::GRP_MSB:psg_pkg::GRP_LSB];
    assign periphReadN = !readStrobe;
    assign periphWriteN = !writeStrobe;

    // Active-low selects per peripheral group.
    // Active-low outputs.
    always_comb begin
        parallelLowSelN = 1'h1;
        parallelHighSelN = 1'h1;
        timerSelN = 1'h1;
        intcSelN = 1'h1;
        serialSelN = 1'h1;
        spareSelN = 4'hF;
        if (ioSelectable && strobeActive) begin
            case (group)
                psg_pkg::GRP_PARALLEL: begin
                    parallelLowSelN = portAddr[0];
                    parallelHighSelN = !(portAddr[0] && !byteHighEnableN);
                end
                psg_pkg::GRP_TIMER: timerSelN = portAddr[0];
                psg_pkg::GRP_INTC: intcSelN = portAddr[0];
                psg_pkg::GRP_SERIAL: serialSelN = portAddr[0];
                default: spareSelN[group[1:0]] = 1'h0;
            endcase
        end
    end

    // Register select lines handed to the peripherals.
    // Two lowest address lines.
    assign registerSelect = portAddr[1:0];
    assign serialCtrlSelect = portAddr[1];

    // Peripheral clock toggles each processor clock for an even duty cycle.
    // Divide by two.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            peripheralClock <= 1'h0;
        end else begin
            peripheralClock <= !peripheralClock;
        end
    end

    // Timer clocks and gates; the link chains counter one behind counter zero.
    // Counters zero and two on peripheral clock.
    assign timerClock[0] = peripheralClock;
    assign timerClock[2] = peripheralClock;
    assign timerClock[1] = counterOneLinkB ? counterOut[0] : peripheralClock;
    assign timerGate = 3'h7;
    // Bit-rate clock from counter two; its rate is set by software.
    assign receiveBitClock = counterOut[2];
    assign transmitBitClock = counterOut[2];

    // Handshake loopback when the link is fitted, else from the line.
    // Loopback link.
    assign serialCtsN = handshakeLoopbackLink ? serialRtsN : lineCtsN;

    // Serial device held in reset through the system reset and one clock after.
    // Serial reset follows system reset.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serialReset <= 1'h1;
        end else begin
            serialReset <= 1'h0;
        end
    end

    // Request routing into the eight controller inputs.
    // Counter outputs as requests.
    assign requests[psg_pkg::IRQ_TIMER0] = counterOut[0];
    assign requests[psg_pkg::IRQ_TIMER1] = counterOut[1];
    assign requests[psg_pkg::IRQ_RX_READY] = receiveReadyFlag;
    assign requests[psg_pkg::IRQ_TX_READY] = transmitReadyFlag;
    // Port C strobe bits as requests.
    assign requests[psg_pkg::IRQ_LOW_PC0] = portCBitZero[0];
    assign requests[psg_pkg::IRQ_LOW_PC3] = portCBitThree[0];
    assign requests[psg_pkg::IRQ_HIGH_PC0] = portCBitZero[1];
    assign requests[psg_pkg::IRQ_HIGH_PC3] = portCBitThree[1];
    assign pending = requests & ~mask;

    // Fixed priority: the lowest numbered pending input wins.
    // Input zero highest.
    always_comb begin
        topLevel = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (pending[i]) begin
                topLevel = 3'(i);
            end
        end
    end

    assign cascadeLine = 3'h0;
    assign masterSlaveProgramInput = 1'h1;

    // Software access to the controller's vector base and mask.
    assign intcAccess = ioSelectable && (group == psg_pkg::GRP_INTC) && !portAddr[0];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            vectorBase <= psg_pkg::VECTOR_BASE_RST;
            mask <= psg_pkg::MASK_RST;
        end else if (writeStrobe && intcAccess) begin
            if (portAddr[1] == psg_pkg::CTL_MASK) begin
                mask <= writeData;
            end else begin
                vectorBase <= {writeData[7:3], 3'h0};
            end
        end
    end

    // Acknowledge sequence: first pulse freezes the level, second returns the vector.
    // Two-pulse acknowledge.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ackState <= psg_pkg::ACK_IDLE;
            heldLevel <= 3'h0;
        end else begin
            case (ackState)
                psg_pkg::ACK_IDLE: begin
                    if (interruptAcknowledgePulse) begin
                        ackState <= psg_pkg::ACK_FIRST;
                        heldLevel <= topLevel;
                    end
                end
                psg_pkg::ACK_FIRST: begin
                    if (interruptAcknowledgePulse) begin
                        ackState <= psg_pkg::ACK_IDLE;
                    end
                end
                default: ackState <= psg_pkg::ACK_IDLE;
            endcase
        end
    end

    // Request raised while any unmasked input is pending and no sequence runs.
    assign cpuInterruptRequest = (|pending) && (ackState == psg_pkg::ACK_IDLE);

    // Read data and bus drive, valid only in the cycle after a read or second pulse.
    // Bus driven only after a strobe.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readData <= 8'h00;
            dataDriveN <= 1'h1;
        end else if (interruptAcknowledgePulse && ackState == psg_pkg::ACK_FIRST) begin
            readData <= vectorBase | {5'h00, heldLevel};
            dataDriveN <= 1'h0;
        end else if (readStrobe && intcAccess) begin
            readData <= (portAddr[1] == psg_pkg::CTL_MASK) ? mask : pending;
            dataDriveN <= 1'h0;
        end else begin
            dataDriveN <= 1'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    no_strobe_sel_a: assert property (!strobeActive |-> (&{parallelLowSelN, timerSelN, intcSelN, serialSelN}))
        else $error("select active without a strobe");
    mem_cycle_sel_a: assert property (memoryCycle |-> (&{parallelLowSelN, parallelHighSelN, timerSelN, intcSelN}))
        else $error("select active in a memory cycle");
    lane_split_a: assert property (!parallelLowSelN |-> !parallelHighSelN == 1'h0)
        else $error("both parallel devices selected");
    pclk_toggle_a: assert property (peripheralClock |=> !peripheralClock ##1 peripheralClock)
        else $error("peripheral clock not halved");
    chain_clock_a: assert property (counterOneLinkB |-> timerClock[1] == counterOut[0])
        else $error("counter one clock not chained");
    serial_reset_a: assert property ($rose(nrst) |=> !serialReset)
        else $error("serial reset lingers");
    priority_top_a: assert property (pending[0] |-> topLevel == 3'h0)
        else $error("level zero not highest");
    vector_out_a: assert property ((interruptAcknowledgePulse && ackState == psg_pkg::ACK_FIRST)
        |=> !dataDriveN && readData[2:0] == $past(heldLevel))
        else $error("vector not placed after second pulse");
    drive_once_a: assert property (!dataDriveN |-> $past(readStrobe || interruptAcknowledgePulse))
        else $error("bus driven without a cause");
    loopback_a: assert property (handshakeLoopbackLink |-> serialCtsN == serialRtsN)
        else $error("handshake loopback broken");
    loop_open_a: assert property (!handshakeLoopbackLink |-> serialCtsN == lineCtsN)
        else $error("line clear-to-send not passed through");

    // Decoder guards: each select answers only inside its own group, lane and address parity.
    // A stray select here would let two peripherals fight over the data bus.
    low_lane_sel_a: assert property (!parallelLowSelN |-> !portAddr[0])
        else $error("low parallel device selected on an odd address");
    high_lane_sel_a: assert property (!parallelHighSelN |-> portAddr[0] && !byteHighEnableN)
        else $error("high parallel device selected off its lane");
    timer_even_a: assert property (!timerSelN |-> !portAddr[0] && group == psg_pkg::GRP_TIMER)
        else $error("timer selected outside its even addresses");
    intc_even_a: assert property (!intcSelN |-> !portAddr[0] && group == psg_pkg::GRP_INTC)
        else $error("controller selected outside its even addresses");
    serial_even_a: assert property (!serialSelN |-> !portAddr[0] && group == psg_pkg::GRP_SERIAL)
        else $error("serial device selected outside its even addresses");
    spare_sel_a: assert property (!spareSelN[3] |-> group == 3'h7 && !memoryCycle)
        else $error("spare select outside its group");
    upper_addr_sel_a: assert property ((portAddr[7:6] != 2'h0)
        |-> &{parallelLowSelN, parallelHighSelN, timerSelN, intcSelN, serialSelN, spareSelN})
        else $error("select active with upper address bits set");
    no_strobe_all_a: assert property (!strobeActive |-> parallelHighSelN && (&spareSelN))
        else $error("high or spare select active without a strobe");
    mem_cycle_all_a: assert property (memoryCycle |-> serialSelN && (&spareSelN))
        else $error("serial or spare select active in a memory cycle");
    reg_select_a: assert property (registerSelect == portAddr[1:0])
        else $error("register select lines not from the low address");
    serial_ctrl_a: assert property (serialCtrlSelect == portAddr[1])
        else $error("serial register choice not from address line one");
    strobe_pins_a: assert property (periphReadN == !readStrobe && periphWriteN == !writeStrobe)
        else $error("peripheral strobes do not follow the bus");

    // Clock, gate and request wiring guards.
    direct_clock_a: assert property (timerClock[0] == peripheralClock && timerClock[2] == peripheralClock)
        else $error("counter zero or two not on the peripheral clock");
    link_a_clock_a: assert property (!counterOneLinkB |-> timerClock[1] == peripheralClock)
        else $error("counter one clock not on the peripheral clock");
    gates_high_a: assert property (timerGate == 3'h7)
        else $error("timer gate low");
    bit_clock_a: assert property (receiveBitClock == counterOut[2] && transmitBitClock == counterOut[2])
        else $error("bit clock not from counter two");
    timer_irq_a: assert property (requests[1:0] == counterOut[1:0])
        else $error("counter outputs not routed as requests");
    serial_irq_a: assert property (requests[3:2] == {transmitReadyFlag, receiveReadyFlag})
        else $error("serial ready flags not routed as requests");
    port_c_irq_a: assert property (requests[7:4]
        == {portCBitThree[1], portCBitZero[1], portCBitThree[0], portCBitZero[0]})
        else $error("port C strobe bits not routed as requests");
    lone_master_a: assert property (cascadeLine == 3'h0 && masterSlaveProgramInput)
        else $error("controller not wired as a lone master");

    // Controller guards: ordering, request drop on acknowledge, masking and vector alignment.
    priority_order_a: assert property ((|pending)
        |-> pending[topLevel] && ((pending & ((8'h01 << topLevel) - 8'h01)) == 8'h00))
        else $error("a higher level was passed over");
    ack_drop_a: assert property ((interruptAcknowledgePulse && ackState == psg_pkg::ACK_IDLE)
        |=> !cpuInterruptRequest)
        else $error("request not dropped after the first pulse");
    ack_hold_a: assert property (ackState == psg_pkg::ACK_FIRST |-> !cpuInterruptRequest)
        else $error("request raised inside an acknowledge sequence");
    masked_quiet_a: assert property (mask == 8'hFF |-> !cpuInterruptRequest)
        else $error("request raised with every level masked");
    vector_align_a: assert property (vectorBase[2:0] == 3'h0)
        else $error("vector base low bits not clear");
    read_answer_a: assert property (readStrobe && intcAccess |=> !dataDriveN)
        else $error("controller read not answered");
    idle_no_drive_a: assert property (!readStrobe && !interruptAcknowledgePulse |=> dataDriveN)
        else $error("bus driven in an idle cycle");

    // Main scenarios: acknowledge pair, register read, serial select, chained clock, masked request.
    ack_seq_c: cover property (interruptAcknowledgePulse ##[1:8] interruptAcknowledgePulse ##1 !dataDriveN);
    intc_read_c: cover property (readStrobe && intcAccess ##1 !dataDriveN);
    serial_sel_c: cover property (!serialSelN);
    chain_clock_c: cover property (counterOneLinkB && counterOut[0]);
    masked_all_c: cover property ((|requests) && !cpuInterruptRequest && ackState == psg_pkg::ACK_IDLE);
endmodule : psg_glue

// ==== verification/psg_far_model.sv ====
// Far-side peripherals model: interval timer outputs, serial flags, parallel port C bits.
// Assumes the bench sets the request levels on reqs, indexed by the controller input positions.
`timescale 1ns/1ps
module psg_far_model (
    input wire logic nrst,
    input wire logic [2:0] timerClock,
    input wire logic [2:0] timerGate,
    input wire logic [7:0] reqs,
    output logic [2:0] counterOut,
    output logic receiveReadyFlag,
    output logic transmitReadyFlag,
    output logic [1:0] portCBitZero,
    output logic [1:0] portCBitThree
);
    // Half the divide figure that software loads into counter two; a small stand-in keeps runs short.
    localparam int RATE_HALF = 3;
    logic rateOut;
    int rateCount;

    // programmed rate counter
    // Counter two counts only while its gate is high and toggles the bit clock every RATE_HALF clocks.
    always_ff @(posedge timerClock[2] or negedge nrst) begin
        if (!nrst) begin
            rateOut <= 1'h0;
            rateCount <= 0;
        end else if (timerGate[2]) begin
            if (rateCount == RATE_HALF - 1) begin
                rateCount <= 0;
                rateOut <= !rateOut;
            end else begin
                rateCount <= rateCount + 1;
            end
        end
    end

    // request sources
    // Counters zero and one and the flags follow the levels the bench commands.
    assign counterOut = {rateOut, reqs[psg_pkg::IRQ_TIMER1], reqs[psg_pkg::IRQ_TIMER0]};
    assign receiveReadyFlag = reqs[psg_pkg::IRQ_RX_READY];
    assign transmitReadyFlag = reqs[psg_pkg::IRQ_TX_READY];
    assign portCBitZero = {reqs[psg_pkg::IRQ_HIGH_PC0], reqs[psg_pkg::IRQ_LOW_PC0]};
    assign portCBitThree = {reqs[psg_pkg::IRQ_HIGH_PC3], reqs[psg_pkg::IRQ_LOW_PC3]};
endmodule : psg_far_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the peripheral select and interrupt glue.
// Assumes one 125 MHz clock and the far-side model beside the design.
`timescale 1ns/1ps
module tb_top;
    logic clock, nrst, byteHighEnableN, memoryCycle, writeStrobe, readStrobe, counterOneLinkB;
    logic handshakeLoopbackLink, serialRtsN, lineCtsN, interruptAcknowledgePulse, receiveReadyFlag;
    logic transmitReadyFlag, dataDriveN, periphReadN, periphWriteN, parallelLowSelN, parallelHighSelN;
    logic timerSelN, intcSelN, serialSelN, serialCtrlSelect, peripheralClock, receiveBitClock;
    logic transmitBitClock, serialReset, serialCtsN, cpuInterruptRequest, masterSlaveProgramInput;
    logic [7:0] portAddr, writeData, readData, reqs;
    logic [3:0] spareSelN;
    logic [2:0] counterOut, timerClock, timerGate, cascadeLine;
    logic [1:0] registerSelect, portCBitZero, portCBitThree;
    wire [8:0] sels = {parallelLowSelN, parallelHighSelN, timerSelN, intcSelN, serialSelN, spareSelN};
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    psg_glue uut (.*);
    psg_far_model far (.*);

    // Clock of 8 ns period.
    always #4 clock = ~clock;

    // Prints the verdict and ends the run.
    task automatic results;
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    // Cuts a hang short far above the few hundred cycles the scenarios need.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    // Compares a value and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One write cycle on the register port.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        portAddr <= a;
        writeData <= d;
        writeStrobe <= 1'h1;
        @(posedge clock);
        writeStrobe <= 1'h0;
    endtask : wr

    // One read cycle; data are judged in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        portAddr <= a;
        readStrobe <= 1'h1;
        @(posedge clock);
        readStrobe <= 1'h0;
        @(negedge clock);
        chk({dataDriveN, readData}, {1'h0, e});
    endtask : rd

    // Resets mid-run or at start, then checks the release and the mask reset value.
    task automatic do_reset(input int n);
        @(posedge clock);
        nrst <= 1'h0;
        repeat (n) @(posedge clock);
        chk({serialReset, dataDriveN, peripheralClock, cpuInterruptRequest}, 4'hC);
        nrst <= 1'h1;
        @(posedge clock);
        @(negedge clock);
        chk(serialReset, 1'h0);
        rd(8'h12, 8'hFF);
    endtask : do_reset

    // One strobe with given decode inputs; selects judged during and after it.
    task automatic sel(input logic [7:0] a, input logic b, m, w, input logic [8:0] e);
        @(posedge clock);
        portAddr <= a;
        byteHighEnableN <= b;
        memoryCycle <= m;
        writeStrobe <= w;
        readStrobe <= !w;
        @(negedge clock);
        chk(sels, e);
        chk({registerSelect, serialCtrlSelect, periphReadN, periphWriteN}, {a[1:0], a[1], w, !w});
        @(posedge clock);
        writeStrobe <= 1'h0;
        readStrobe <= 1'h0;
        memoryCycle <= 1'h0;
        @(negedge clock);
        chk({sels, dataDriveN}, {9'h1FF, w | e[5]});
    endtask : sel

    // Walks the port decoder over groups zero to four and seven, odd addresses and refused cycles.
    task automatic decode_scan;
        logic [18:0] t [13];
        t = '{{8'h00, 2'h2, 9'h0FF}, {8'h01, 2'h0, 9'h17F}, {8'h01, 2'h2, 9'h1FF}, {8'h08, 2'h2, 9'h1BF},
              {8'h09, 2'h2, 9'h1FF}, {8'h10, 2'h2, 9'h1DF}, {8'h13, 2'h2, 9'h1FF}, {8'h1A, 2'h2, 9'h1EF},
              {8'h19, 2'h2, 9'h1FF}, {8'h20, 2'h2, 9'h1FE}, {8'h38, 2'h2, 9'h1F7}, {8'h40, 2'h2, 9'h1FF},
              {8'h00, 2'h3, 9'h1FF}};
        for (int i = 0; i < 13; i++) sel(t[i][18:11], t[i][10], t[i][9], i[0], t[i][8:0]);
    endtask : decode_scan

    // Checks timer clock routing, link positions, gates and the peripheral clock.
    task automatic timers;
        logic p;
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            counterOneLinkB <= k[2];
            reqs <= {7'h0, k[0]};
            @(negedge clock);
            p = peripheralClock;
            chk(timerClock, {p, k[2] ? k[0] : p, p});
            chk({receiveBitClock, transmitBitClock, timerGate}, {{2{counterOut[2]}}, 3'h7});
            @(negedge clock);
            chk(peripheralClock, !p);
        end
        @(posedge clock);
        reqs <= 8'h00;
    endtask : timers

    // acknowledge pulse
    // One processor acknowledge pulse, then waits for the settled answer.
    task automatic ack;
        @(posedge clock);
        interruptAcknowledgePulse <= 1'h1;
        @(posedge clock);
        interruptAcknowledgePulse <= 1'h0;
        @(negedge clock);
    endtask : ack

    // Raises requests under a mask and runs the acknowledge sequence.
    task automatic irq(input logic [7:0] r, input logic [7:0] m, input int lvl);
        wr(8'h12, m);
        @(posedge clock);
        reqs <= r;
        @(negedge clock);
        chk(cpuInterruptRequest, |(r & ~m));
        rd(8'h10, r & ~m);
        if (|(r & ~m)) begin
            ack();
            chk(cpuInterruptRequest, 1'h0);
            ack();
            chk({dataDriveN, readData}, {1'h0, 8'h40 | lvl[7:0]});
        end
        @(posedge clock);
        reqs <= 8'h00;
    endtask : irq

    // Each source alone and then with every lower-priority level also pending, level by level, masking last.
    task automatic interrupts;
        wr(8'h10, 8'h47);
        for (int lv = 0; lv < 8; lv++) begin
            irq(8'h01 << lv, 8'h00, lv);
            irq(8'hFF << lv, 8'h00, lv);
        end
        irq(8'hFF, 8'hDF, 5);
        irq(8'hFF, 8'hFF, 0);
    endtask : interrupts

    // Handshake loopback link, fixed controller pins and a reset in mid-run.
    task automatic misc;
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            {handshakeLoopbackLink, serialRtsN, lineCtsN} <= k[2:0];
            @(negedge clock);
            chk(serialCtsN, k[2] ? k[1] : k[0]);
        end
        chk({cascadeLine, masterSlaveProgramInput}, 4'h1);
        wr(8'h12, 8'h00);
        do_reset(3);
    endtask : misc

    // Main sequence.
    initial begin
        clock = 1'h0;
        nrst = 1'h0;
        {portAddr, writeData, reqs} = '0;
        {byteHighEnableN, serialRtsN, lineCtsN} = 3'h7;
        {memoryCycle, writeStrobe, readStrobe, counterOneLinkB} = 4'h0;
        {handshakeLoopbackLink, interruptAcknowledgePulse} = 2'h0;
        do_reset(11);
        decode_scan();
        timers();
        interrupts();
        misc();
        results();
    end
endmodule : tb_top
